//--- event_flag_and_mask_bank.sv
`timescale 1ns/1ps
`include "evt_map.svh"
// Behaviour
// - Timer/fault events at 0x6, reset zero, whole register clears when read.
// - Watchdog expiry sets bit 6, held until read.
// - Safety timer expiry sets bit 5, held until read.
// - Regulator overcurrent sets bit 4; zero means regulator normal.
// - First button wake timer expiry sets bit 2, held until read.
// - Second button wake timer expiry sets bit 1, held until read.
// - Button reset warning expiry sets bit 0, held until read.
// - Charge-status mask at 0x7, read/write, resets to zero.
// - Mask bit one suppresses the event interrupt, zero allows it.
// - Charge mask bit 6 constant voltage, bit 5 termination.
// - Charge mask bit 4 input current limit, bit 2 voltage DPM.
// - Charge mask bit 1 thermal, bit 0 power good; 7,3 reserved.
// - Fault mask at 0x8, read/write, resets to zero.
// - Fault mask bit 7 input overvoltage; bit 6 reserved.
// - Fault mask bit 5 battery overcurrent, bit 4 undervoltage.
// - Fault mask bits 3..0 thermistor cold, cool, warm, hot.
// - Clear-on-read fault events at 0x4, governed by fault mask.
module event_flag_and_mask_bank #(
  parameter logic [6:0] DEV_ADDR = `SER_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Serial register port
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // Event inputs from the detectors
  input  wire evt_pkg::timer_events_s  timer_evt,
  input  wire evt_pkg::fault_events_s  fault_evt,
  input  wire evt_pkg::charge_events_s charge_evt,
  // Interrupt pulse
  output logic                         irq
);
  import evt_pkg::*;

  bank_state_s st;
  bank_state_s nx;

  logic [7:0] t_set;
  logic [7:0] f_set;
  logic [7:0] c_set;
  logic [7:0] t_flags;
  logic [7:0] f_flags;
  logic [7:0] t_fresh;
  logic [7:0] f_fresh;
  logic [7:0] rd_byte;
  logic       load;
  logic       wr_en;
  logic       clr_timer;
  logic       clr_fault;
  logic       irq_cause;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  // Address match
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] r);
    reg_hit = (a == r);
  endfunction : reg_hit

  // Read data for a register pointer
  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input logic [7:0] tf,
                                          input logic [7:0] ff,
                                          input logic [7:0] m0,
                                          input logic [7:0] m1);
    reg_read = 8'h00;
    if (reg_hit(a, `REG_TIMER_EVENTS)) begin
      reg_read = tf;
    end else if (reg_hit(a, `REG_FAULT_EVENTS)) begin
      reg_read = ff;
    end else if (reg_hit(a, `REG_CHARGE_MASK)) begin
      reg_read = m0;
    end else if (reg_hit(a, `REG_FAULT_MASK)) begin
      reg_read = m1;
    end
  endfunction : reg_read

  // Place event inputs at their register bit positions
  always_comb begin
    t_set = 8'h00;
    f_set = 8'h00;
    c_set = 8'h00;
    t_set[`TE_WATCHDOG] = timer_evt.watchdog_expired;
    t_set[`TE_SAFETY]   = timer_evt.safety_timer_expired;
    t_set[`TE_REG_OC]   = timer_evt.regulator_overcurrent;
    t_set[`TE_WAKE1]    = timer_evt.button_wake_first_expired;
    t_set[`TE_WAKE2]    = timer_evt.button_wake_second_expired;
    t_set[`TE_RST_WARN] = timer_evt.button_reset_warning;
    f_set[`FE_IN_OV]    = fault_evt.input_overvoltage;
    f_set[`FE_BAT_OC]   = fault_evt.battery_overcurrent;
    f_set[`FE_BAT_UV]   = fault_evt.battery_undervoltage;
    f_set[`FE_TS_COLD]  = fault_evt.thermistor_cold;
    f_set[`FE_TS_COOL]  = fault_evt.thermistor_cool;
    f_set[`FE_TS_WARM]  = fault_evt.thermistor_warm;
    f_set[`FE_TS_HOT]   = fault_evt.thermistor_hot;
    c_set[`CS_CV]       = charge_evt.const_voltage_entry;
    c_set[`CS_DONE]     = charge_evt.charge_done;
    c_set[`CS_ILIM]     = charge_evt.input_current_limit;
    c_set[`CS_VDPM]     = charge_evt.input_voltage_dpm;
    c_set[`CS_THERM]    = charge_evt.thermal_regulation;
    c_set[`CS_PGOOD]    = charge_evt.input_power_good;
  end

  // Timer and fault event register
  sticky_flag_reg #(
    .VALID (`TIMER_VALID)
  ) u_timer_flags (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (t_set),
    .clr     (clr_timer),
    .flags   (t_flags),
    .fresh   (t_fresh)
  );

  // Supply, battery and thermistor fault event register
  sticky_flag_reg #(
    .VALID (`FAULT_VALID)
  ) u_fault_flags (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (f_set),
    .clr     (clr_fault),
    .flags   (f_flags),
    .fresh   (f_fresh)
  );

  // Bus conditions from the synchronised pins
  assign scl_rise = st.scl_s2 & ~st.scl_s3;
  assign scl_fall = ~st.scl_s2 & st.scl_s3;
  assign start    = st.scl_s2 & st.scl_s3 & st.sda_s3 & ~st.sda_s2;
  assign stop     = st.scl_s2 & st.scl_s3 & ~st.sda_s3 & st.sda_s2;

  // Read side effects and interrupt cause
  assign rd_byte   = reg_read(st.ptr, t_flags, f_flags,
                              st.charge_status_irq_mask,
                              st.supply_thermal_fault_mask);
  assign clr_timer = load && reg_hit(st.ptr, `REG_TIMER_EVENTS);
  assign clr_fault = load && reg_hit(st.ptr, `REG_FAULT_EVENTS);
  // Timer events carry no mask in this bank
  assign irq_cause = (|t_fresh)
    | (|(f_fresh & ~st.supply_thermal_fault_mask))
    | (|(c_set & `CHARGE_VALID & ~st.charge_status_irq_mask));

  // Serial target, register writes and interrupt
  always_comb begin
    nx = st;
    load = 1'b0;
    wr_en = 1'b0;
    nx.scl_s1 = scl_in;
    nx.scl_s2 = st.scl_s1;
    nx.scl_s3 = st.scl_s2;
    nx.sda_s1 = sda_in;
    nx.sda_s2 = st.sda_s1;
    nx.sda_s3 = st.sda_s2;
    nx.irq = irq_cause;
    if (start) begin
      nx.state = S_ADDR;
      nx.cnt = 4'h0;
      nx.sda_oe = 1'b0;
    end else if (stop) begin
      nx.state = S_IDLE;
      nx.sda_oe = 1'b0;
    end else begin
      unique case (st.state)
        S_IDLE: begin
          nx.sda_oe = 1'b0;
        end
        S_ADDR, S_REG, S_WDATA: begin
          if (scl_rise) begin
            nx.sh = {st.sh[6:0], st.sda_s2};
            nx.cnt = st.cnt + 4'h1;
          end else if (scl_fall && st.cnt == `SER_BITS) begin
            nx.cnt = 4'h0;
            nx.sda_oe = 1'b1;
            nx.state = S_ACK_W;
            if (st.state == S_ADDR) begin
              if (st.sh[7:1] == DEV_ADDR) begin
                nx.rw = st.sh[0];
                nx.state = S_ACK_ADDR;
              end else begin
                nx.sda_oe = 1'b0;
                nx.state = S_IDLE;
              end
            end else if (st.state == S_REG) begin
              nx.ptr = st.sh;
            end else begin
              wr_en = 1'b1;
              nx.ptr = st.ptr + 8'h01;
            end
          end
        end
        S_ACK_ADDR: begin
          if (scl_fall) begin
            nx.cnt = 4'h0;
            if (st.rw) begin
              load = 1'b1;
              nx.sh = rd_byte;
              nx.sda_oe = ~rd_byte[7];
              nx.ptr = st.ptr + 8'h01;
              nx.state = S_RDATA;
            end else begin
              nx.sda_oe = 1'b0;
              nx.state = S_REG;
            end
          end
        end
        S_ACK_W: begin
          if (scl_fall) begin
            nx.sda_oe = 1'b0;
            nx.state = S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (st.cnt == `SER_LAST) begin
              nx.sda_oe = 1'b0;
              nx.state = S_ACK_R;
            end else begin
              nx.cnt = st.cnt + 4'h1;
              nx.sh = {st.sh[6:0], 1'b0};
              nx.sda_oe = ~st.sh[6];
            end
          end
        end
        S_ACK_R: begin
          if (scl_rise) begin
            nx.nack = st.sda_s2;
          end else if (scl_fall) begin
            nx.cnt = 4'h0;
            if (st.nack) begin
              nx.state = S_IDLE;
            end else begin
              load = 1'b1;
              nx.sh = rd_byte;
              nx.sda_oe = ~rd_byte[7];
              nx.ptr = st.ptr + 8'h01;
              nx.state = S_RDATA;
            end
          end
        end
        default: begin
          nx.state = S_IDLE;
          nx.sda_oe = 1'b0;
        end
      endcase
    end
    // Mask writes; event registers ignore writes
    if (wr_en && reg_hit(st.ptr, `REG_CHARGE_MASK)) begin
      nx.charge_status_irq_mask = st.sh;
    end
    if (wr_en && reg_hit(st.ptr, `REG_FAULT_MASK)) begin
      nx.supply_thermal_fault_mask = st.sh;
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{state: S_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
              sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, default: '0};
    end else begin
      st <= nx;
    end
  end

  assign sda_out = st.sda_out;
  assign sda_oe  = st.sda_oe;
  assign irq     = st.irq;

  property p_watchdog;
    @(posedge clk) disable iff (sys_rst)
    timer_evt.watchdog_expired |=> t_flags[`TE_WATCHDOG];
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog flag not set");

  property p_safety;
    @(posedge clk) disable iff (sys_rst)
    timer_evt.safety_timer_expired |=> t_flags[`TE_SAFETY];
  endproperty
  a_safety: assert property (p_safety)
    else $error("safety timer flag not set");

  property p_reg_oc;
    @(posedge clk) disable iff (sys_rst)
    timer_evt.regulator_overcurrent |=> t_flags[`TE_REG_OC];
  endproperty
  a_reg_oc: assert property (p_reg_oc)
    else $error("regulator overcurrent flag not set");

  property p_buttons;
    @(posedge clk) disable iff (sys_rst)
    (timer_evt.button_wake_first_expired ##1 !clr_timer[*2])
      |-> t_flags[`TE_WAKE1];
  endproperty
  a_buttons: assert property (p_buttons)
    else $error("button wake flag lost before read");

  property p_timer_clear;
    @(posedge clk) disable iff (sys_rst)
    (clr_timer && t_set == 8'h00) |=> (t_flags == `REG_RESET);
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer register not cleared by read");

  property p_charge_status_irq_mask_write;
    @(posedge clk) disable iff (sys_rst)
    (wr_en && st.ptr == `REG_CHARGE_MASK)
      |=> (st.charge_status_irq_mask == $past(st.sh));
  endproperty
  a_charge_status_irq_mask_write: assert property (p_charge_status_irq_mask_write)
    else $error("charge mask write lost");

  property p_supply_thermal_fault_mask_write;
    @(posedge clk) disable iff (sys_rst)
    (wr_en && st.ptr == `REG_FAULT_MASK)
      |=> (st.supply_thermal_fault_mask == $past(st.sh));
  endproperty
  a_supply_thermal_fault_mask_write: assert property (p_supply_thermal_fault_mask_write)
    else $error("fault mask write lost");

  property p_irq_cause;
    @(posedge clk) disable iff (sys_rst)
    irq |-> $past(irq_cause);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without unmasked new event");

  property p_masked_fault;
    @(posedge clk) disable iff (sys_rst)
    (t_set == 8'h00 && (c_set & ~st.charge_status_irq_mask) == 8'h00
      && (f_set & ~st.supply_thermal_fault_mask) == 8'h00) |=> !irq;
  endproperty
  a_masked_fault: assert property (p_masked_fault)
    else $error("masked event raised interrupt");

  property p_stop_release;
    @(posedge clk) disable iff (sys_rst)
    stop |=> !sda_oe ##1 !sda_oe;
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("data line held after stop");

  c_timer_read: cover property (@(posedge clk) disable iff (sys_rst)
    clr_timer && t_flags != 8'h00);
  c_mask_write: cover property (@(posedge clk) disable iff (sys_rst)
    wr_en && st.ptr == `REG_FAULT_MASK);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) irq);

endmodule : event_flag_and_mask_bank

//--- evt_map.svh
`ifndef EVT_MAP_SVH
`define EVT_MAP_SVH

// Register offsets
`define REG_FAULT_EVENTS 8'h04
`define REG_TIMER_EVENTS 8'h06
`define REG_CHARGE_MASK  8'h07
`define REG_FAULT_MASK   8'h08

// Reset value shared by all registers of the bank
`define REG_RESET 8'h00

// Implemented bits of each event set; reserved event flag bits stay zero, mask bits all writable
`define TIMER_VALID  8'h77
`define FAULT_VALID  8'hBF
`define CHARGE_VALID 8'h77

// Timer and fault event bit positions
`define TE_WATCHDOG 6
`define TE_SAFETY   5
`define TE_REG_OC   4
`define TE_WAKE1    2
`define TE_WAKE2    1
`define TE_RST_WARN 0

// Charge-status mask bit positions
`define CS_CV      6
`define CS_DONE    5
`define CS_ILIM    4
`define CS_VDPM    2
`define CS_THERM   1
`define CS_PGOOD   0

// Fault event and mask bit positions
`define FE_IN_OV   7
`define FE_BAT_OC  5
`define FE_BAT_UV  4
`define FE_TS_COLD 3
`define FE_TS_COOL 2
`define FE_TS_WARM 1
`define FE_TS_HOT  0

// Serial port bit counts and default target address (arbitrary)
`define SER_BITS      4'h8
`define SER_LAST      4'h7
`define SER_ADDR_DFLT 7'h2A

`endif

//--- evt_pkg.sv
package evt_pkg;

  // Serial port states, one-hot
  typedef enum logic [7:0] {
    S_IDLE     = 8'h01,
    S_ADDR     = 8'h02,
    S_ACK_ADDR = 8'h04,
    S_REG      = 8'h08,
    S_WDATA    = 8'h10,
    S_ACK_W    = 8'h20,
    S_RDATA    = 8'h40,
    S_ACK_R    = 8'h80
  } ser_state_e;

  // Timer and fault events from the detectors
  typedef struct packed {
    logic watchdog_expired;
    logic safety_timer_expired;
    logic regulator_overcurrent;
    logic button_wake_first_expired;
    logic button_wake_second_expired;
    logic button_reset_warning;
  } timer_events_s;

  // Supply, battery and thermistor fault events
  typedef struct packed {
    logic input_overvoltage;
    logic battery_overcurrent;
    logic battery_undervoltage;
    logic thermistor_cold;
    logic thermistor_cool;
    logic thermistor_warm;
    logic thermistor_hot;
  } fault_events_s;

  // Charge-status events
  typedef struct packed {
    logic const_voltage_entry;
    logic charge_done;
    logic input_current_limit;
    logic input_voltage_dpm;
    logic thermal_regulation;
    logic input_power_good;
  } charge_events_s;

  // State of one sticky flag register
  typedef struct packed {
    logic [7:0] flags;
  } flag_state_s;

  // State of the bank top
  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_s3;
    ser_state_e state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rw;
    logic       nack;
    logic       sda_oe;
    logic       sda_out;
    logic [7:0] charge_status_irq_mask;
    logic [7:0] supply_thermal_fault_mask;
    logic       irq;
  } bank_state_s;

endpackage : evt_pkg

//--- sticky_flag_reg.sv
`timescale 1ns/1ps
`include "evt_map.svh"
module sticky_flag_reg #(
  parameter logic [7:0] VALID = 8'hFF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Event inputs and read strobe
  input  wire logic [7:0] set,
  input  wire logic       clr,
  // Flag contents and newly raised events
  output logic      [7:0] flags,
  output logic      [7:0] fresh
);
  import evt_pkg::*;

  flag_state_s st;
  flag_state_s nx;

  // Sticky set, clear on read, set wins over clear
  always_comb begin
    nx = st;
    nx.flags = (st.flags & ~{8{clr}}) | (set & VALID);
  end

  // Flag registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.flags <= `REG_RESET;
    end else begin
      st <= nx;
    end
  end

  assign flags = st.flags;
  // Event counts as new if flag was clear or is being cleared
  assign fresh = set & VALID & (~st.flags | {8{clr}});

  property p_set_sticky;
    @(posedge clk) disable iff (sys_rst)
    (|(set & VALID)) |=>
      ((flags & $past(set & VALID)) == $past(set & VALID));
  endproperty
  a_set_sticky: assert property (p_set_sticky)
    else $error("event did not set its flag");

  property p_clear_on_read;
    @(posedge clk) disable iff (sys_rst)
    (clr && set == 8'h00) |=> (flags == `REG_RESET);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("flags not cleared by read");

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
    !clr |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without a read");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
    (flags & ~VALID) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved flag bit set");

endmodule : sticky_flag_reg

//--- host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter logic [6:0] TARGET = 7'h2A,
  parameter int         HALF   = 8
) (
  // Bench clock
  input  wire logic clk,
  // Bus wires, data line resolved by the bench
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus: both lines released high
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Wait whole clock periods, ending on a falling edge
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap

  // One bus clock: data set while low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    r = sda;
    scl = 1'b0;
    gap(HALF / 2);
  endtask : bit_io

  // Start or repeated start, data falls while clock high
  task automatic start_cond();
    sda_drv = 1'b1;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    sda_drv = 1'b0;
    gap(HALF);
    scl = 1'b0;
    gap(HALF / 2);
  endtask : start_cond

  // Stop, data rises while clock high; bus left idle
  task automatic stop_cond();
    sda_drv = 1'b0;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    sda_drv = 1'b1;
    gap(HALF);
  endtask : stop_cond

  // Byte out msb first, ninth clock samples the target's ack
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_out

  // Byte in msb first; host acks unless last
  task automatic byte_in(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
  endtask : byte_in

  // Register write: address, pointer, one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic k0, k1, k2;
    start_cond();
    byte_out({TARGET, 1'b0}, k0);
    byte_out(a, k1);
    byte_out(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg

  // Register read: pointer, repeated start, one byte with host nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic k0, k1, k2;
    start_cond();
    byte_out({TARGET, 1'b0}, k0);
    byte_out(a, k1);
    start_cond();
    byte_out({TARGET, 1'b1}, k2);
    byte_in(1'b1, d);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg

  // Two bytes from consecutive registers; host acks the first
  task automatic read_pair(input logic [7:0] a, output logic [15:0] d,
                           output logic ok);
    logic k0, k1, k2;
    start_cond();
    byte_out({TARGET, 1'b0}, k0);
    byte_out(a, k1);
    start_cond();
    byte_out({TARGET, 1'b1}, k2);
    byte_in(1'b0, d[15:8]);
    byte_in(1'b1, d[7:0]);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_pair
endmodule : host_model

//--- event_flag_and_mask_bank_bench.sv
`timescale 1ns/1ps
`include "evt_map.svh"
module event_flag_and_mask_bank_bench;
  import evt_pkg::*;
  // Clock, reset, bus and event wires
  logic           clk;
  logic           sys_rst;
  logic           scl;
  logic           sda_drv;
  wire logic      sda;
  logic           sda_out;
  logic           sda_oe;
  logic           irq;
  timer_events_s  timer_evt;
  fault_events_s  fault_evt;
  charge_events_s charge_evt;
  int             err_count;
  int             checked;
  logic [7:0]     e;
  logic [15:0]    pair;
  logic           pair_ok;
  // Register bit of each struct field, lsb field first
  int tpos[6] = '{`TE_RST_WARN, `TE_WAKE2, `TE_WAKE1, `TE_REG_OC,
                  `TE_SAFETY, `TE_WATCHDOG};
  int cpos[6] = '{`CS_PGOOD, `CS_THERM, `CS_VDPM, `CS_ILIM,
                  `CS_DONE, `CS_CV};
  int fpos[7] = '{`FE_TS_HOT, `FE_TS_WARM, `FE_TS_COOL, `FE_TS_COLD,
                  `FE_BAT_UV, `FE_BAT_OC, `FE_IN_OV};
  logic [7:0] pat[4] = '{8'h55, 8'hAA, 8'hFF, 8'h00};

  // Open-drain data line with pull-up
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  // Device under test
  event_flag_and_mask_bank i_dut (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .scl_in    (scl),
    .sda_in    (sda),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .timer_evt (timer_evt),
    .fault_evt (fault_evt),
    .charge_evt(charge_evt),
    .irq       (irq)
  );

  // Host on the serial port
  host_model #(.TARGET(`SER_ADDR_DFLT)) i_host (
    .clk    (clk),
    .sda    (sda),
    .scl    (scl),
    .sda_drv(sda_drv)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask : check

  // Register write with ack check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_host.write_reg(a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask : wr

  // Register read with ack and data check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d;
    i_host.read_reg(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rd

  // One-cycle event, irq checked next cycle and after
  task automatic pulse(input int kind, input int idx, input logic exp);
    case (kind)
      0: timer_evt = timer_events_s'(6'h01 << idx);
      1: fault_evt = fault_events_s'(7'h01 << idx);
      default: charge_evt = charge_events_s'(6'h01 << idx);
    endcase
    @(negedge clk);
    check({7'h00, irq}, {7'h00, exp});
    timer_evt  = '0;
    fault_evt  = '0;
    charge_evt = '0;
    @(negedge clk);
    check({7'h00, irq}, 8'h00);
  endtask : pulse

  // Reset pulse of two cycles, then settle before bus traffic
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask : do_reset

  // Verdict and end of run
  task automatic test_done();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hung run
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    test_done();
  end

  // Main sequence
  initial begin
    err_count  = 0;
    checked    = 0;
    timer_evt  = '0;
    fault_evt  = '0;
    charge_evt = '0;
    do_reset();
    rd(`REG_TIMER_EVENTS, `REG_RESET);
    rd(`REG_CHARGE_MASK, `REG_RESET);
    rd(`REG_FAULT_MASK, `REG_RESET);
    rd(`REG_FAULT_EVENTS, `REG_RESET);
    // Mask registers hold every pattern
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CHARGE_MASK, pat[i]);
      wr(`REG_FAULT_MASK, ~pat[i]);
      rd(`REG_CHARGE_MASK, pat[i]);
      rd(`REG_FAULT_MASK, ~pat[i]);
    end
    // Two-byte read walks the pointer across both masks
    i_host.read_pair(`REG_CHARGE_MASK, pair, pair_ok);
    check({7'h00, pair_ok}, 8'h01);
    check(pair[15:8], 8'h00);
    check(pair[7:0], 8'hFF);
    // Event register ignores writes
    wr(`REG_TIMER_EVENTS, 8'hFF);
    rd(`REG_TIMER_EVENTS, `REG_RESET);
    // Each timer event sets its own bit, cleared by the read
    for (int i = 0; i < 6; i++) begin
      e = 8'(1 << tpos[i]);
      pulse(0, i, 1'b1);
      rd(`REG_TIMER_EVENTS, e);
      rd(`REG_TIMER_EVENTS, `REG_RESET);
    end
    // Flags accumulate until read
    pulse(0, 5, 1'b1);
    pulse(0, 4, 1'b1);
    pulse(0, 5, 1'b0);
    rd(`REG_TIMER_EVENTS, 8'h60);
    // Fault events: own mask bit blocks irq, flag still set
    for (int i = 0; i < 7; i++) begin
      e = 8'(1 << fpos[i]);
      wr(`REG_FAULT_MASK, e);
      pulse(1, i, 1'b0);
      rd(`REG_FAULT_EVENTS, e);
      wr(`REG_FAULT_MASK, ~e);
      pulse(1, i, 1'b1);
      rd(`REG_FAULT_EVENTS, e);
    end
    // Charge events: own mask bit blocks irq, others do not
    for (int i = 0; i < 6; i++) begin
      e = 8'(1 << cpos[i]);
      wr(`REG_CHARGE_MASK, e);
      pulse(2, i, 1'b0);
      wr(`REG_CHARGE_MASK, ~e);
      pulse(2, i, 1'b1);
    end
    // Reset in mid-run clears masks and flags
    wr(`REG_FAULT_MASK, 8'hFF);
    pulse(0, 0, 1'b1);
    do_reset();
    rd(`REG_TIMER_EVENTS, `REG_RESET);
    rd(`REG_CHARGE_MASK, `REG_RESET);
    rd(`REG_FAULT_MASK, `REG_RESET);
    test_done();
  end
endmodule : event_flag_and_mask_bank_bench
